//--- bench/frs_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Port-level checks on the fog and raster parameter registers
module frs_regs_checker #(
    parameter ADDR_W = 10
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic paramValid,
    input wire logic [31:0] paramWord,
    input wire logic fogFromShader,
    input wire logic fogBlendEquation,
    input wire logic fogCoordZ,
    input wire logic fogCoordAttr,
    input wire logic fogModeLocal,
    input wire logic fogModeLinear,
    input wire logic fogModeExp,
    input wire logic fogModeExp2,
    input wire logic fogModeReserved,
    input wire logic shaderLocationUsed,
    input wire logic [11:0] pixelY,
    input wire logic [11:0] locationY,
    input wire logic locationYSubtract
);
    // One clock domain, reset disables every check
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // Bus answers
    AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before handshake");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before handshake");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    AST_TOP_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
        else $error("upper read byte not zero");
    AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 10'h1d0 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("reserved word answered wrongly");

    ////////////////////////////////////////////////////////////////////////////
    // Decoded controls
    AST_MODE_ONEHOT: assert property ($onehot({fogModeLocal, fogModeLinear, fogModeExp,
        fogModeExp2, fogModeReserved}))
        else $error("fog mode decode not one-hot");
    AST_COORD: assert property (fogCoordZ |-> !fogCoordAttr)
        else $error("depth coordinate chosen while attribute selected");
    AST_PARAM_CTL: assert property (paramValid && paramWord[31:24] == 8'h70
        && !s_axi_awvalid ##1 !paramValid |=> fogBlendEquation == $past(paramWord[3], 2)
        && fogFromShader == $past(paramWord[7], 2))
        else $error("fog control not taken from parameter word");
    AST_LOC_Y: assert property (!shaderLocationUsed |=> !locationYSubtract
        && locationY == $past(pixelY))
        else $error("location Y not plain pixel Y");

    // Main scenarios reached
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (paramValid && paramWord[31:24] == 8'h70);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // frs_regs_checker

bind frs_fog_raster_regs frs_regs_checker #(.ADDR_W(ADDR_W)) i_frs_regs_checker (.*);
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_map.vh"
module tb_top;
    // Stimulus, all driven from time zero
    logic ref_clk = 1'b0, rst_n = 1'b0;
    logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, paramValid = 0, lineStart = 0, linePixelStep = 0;
    logic shaderLocationUsed = 0;
    logic [31:0] s_axi_wdata = '0, paramWord = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [11:0] pixelY = '0;
    // Observed outputs
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic fogFromShader, fogCoordAttr, fogCoordZ, fogFromSpecAlpha, fogBlendEquation;
    wire logic fogModeLocal, fogModeLinear, fogModeExp, fogModeExp2, fogModeReserved;
    wire logic [10:0] fogColourRed, fogColourGreen, fogColourBlue;
    wire logic [14:0] fogStart, fogEnd;
    wire logic [3:0] fogRecipMantissa;
    wire logic [7:0] fogRecipExponent, solidRed, solidGreen, solidBlue, solidAlpha;
    wire logic [12:0] fogDensity, guardLeftLimit, guardRightLimit;
    wire logic [11:0] colourClipTop, colourClipBottom, colourClipLeft, colourClipRight;
    wire logic [11:0] scissorTop, scissorBottom, scissorLeft, scissorRight, locationY;
    wire logic texcoordPrecisionBoost, texcoordRoundMode, diffusePremodulated;
    wire logic specularPremodulated, fogPremodulated, locationYSubtract, stippleOn;
    int nErrors = 0, samplesChecked = 0, cycles = 0;
    // Sub-address and readable mask of every mapped word
    localparam bit [31:0] REGS [19] = '{32'h700000ff, 32'h717ff7ff, 32'h720007ff,
        32'h73007fff, 32'h7500000f, 32'h760000ff, 32'h77007fff, 32'h781fff00, 32'h80ffffff,
        32'h81ffffff, 32'h82ffffff, 32'h83ffffff, 32'h8400ffff, 32'h8500ffff, 32'h86ffffff,
        32'h870000ff, 32'h88001fff, 32'h89001fff, 32'h8a81ffff};
    localparam bit [23:0] PAT = 24'h5aa5c3;

    frs_fog_raster_regs #(.ADDR_W(10)) i_frs_fog_raster_regs (.*);

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            nErrors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic conclude();
        if (nErrors == 0 && samplesChecked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            nErrors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Write one word, hold each channel until taken, wait for the response
    task automatic axiWrite(input logic [7:0] sub, input logic [23:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_awaddr <= {sub, 2'b00};
        s_axi_wdata <= {8'h00, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        chk("bresp", {1'b1, er}, {s_axi_bvalid, s_axi_bresp});
        s_axi_bready <= 1'b0;
    endtask
    // Read one word and compare data and response
    task automatic axiRead(input logic [7:0] sub, input logic [23:0] exp, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_araddr <= {sub, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        chk("rdata", {1'b1, er, 8'h00, exp}, {s_axi_rvalid, s_axi_rresp, s_axi_rdata});
        s_axi_rready <= 1'b0;
    endtask
    // One parameter word from the command stream
    task automatic param(input logic [7:0] sub, input logic [23:0] d);
        @(posedge ref_clk);
        paramValid <= 1'b1;
        paramWord <= {sub, d};
        @(posedge ref_clk);
        paramValid <= 1'b0;
    endtask
    task automatic step(input bit first);
        @(posedge ref_clk);
        if (first) lineStart <= 1'b1; else linePixelStep <= 1'b1;
        @(posedge ref_clk);
        lineStart <= 1'b0;
        linePixelStep <= 1'b0;
        cyc(3);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic testReset();
        chk("resetOut", 4'h8, {fogModeLocal, fogModeReserved, fogFromShader, stippleOn});
        axiRead(8'h70, 24'h0, 2'h0);
    endtask
    // Every word written all ones, then a pattern; reserved bits read zero
    task automatic testTable();
        logic [23:0] p;
        for (int j = 0; j < 2; j++)
        begin
            p = j ? PAT : 24'hffffff;
            for (int i = 0; i < 19; i++) axiWrite(REGS[i][31:24], p, 2'h0);
            for (int i = 0; i < 19; i++) axiRead(REGS[i][31:24], p & REGS[i][23:0], 2'h0);
        end
        cyc(2);
        chk("fogColour", {PAT[22:12], PAT[10:0], PAT[10:0]},
            {fogColourGreen, fogColourBlue, fogColourRed});
        chk("fogRange", {PAT[14:0], PAT[14:0]}, {fogStart, fogEnd});
        chk("fogRecip", {PAT[3:0], PAT[7:0]}, {fogRecipMantissa, fogRecipExponent});
        chk("fogDensity", PAT[20:8], fogDensity);
        chk("colourClip", {PAT, PAT}, {colourClipTop, colourClipBottom,
            colourClipLeft, colourClipRight});
        chk("scissor", {PAT, PAT}, {scissorTop, scissorBottom, scissorLeft, scissorRight});
        chk("solid", {PAT, PAT[7:0]}, {solidRed, solidGreen, solidBlue, solidAlpha});
        chk("guard", {PAT[12:0], PAT[12:0]}, {guardLeftLimit, guardRightLimit});
        chk("misc", {PAT[23], PAT[16], PAT[2:0]}, {texcoordPrecisionBoost, texcoordRoundMode,
            diffusePremodulated, specularPremodulated, fogPremodulated});
    endtask
    task automatic testUnmapped();
        logic [7:0] s [4] = '{8'h74, 8'h79, 8'h8b, 8'h8f};
        for (int i = 0; i < 4; i++)
        begin
            axiWrite(s[i], 24'hffffff, 2'h2);
            axiRead(s[i], 24'h0, 2'h2);
        end
    endtask
    // All eight mode codes with the control bits varied alongside
    task automatic testFogCtl();
        logic [2:0] m;
        for (int i = 0; i < 8; i++)
        begin
            m = i[2:0];
            axiWrite(8'h70, {16'h0, m[0], m[1], m[2], ~m[0], m[1] ^ m[0], m}, 2'h0);
            cyc(2);
            chk("fogModes", {m == 0, m == 2, m == 4, m == 5, m == 1 || m == 3 || m > 5},
                {fogModeLocal, fogModeLinear, fogModeExp, fogModeExp2, fogModeReserved});
            chk("fogBits", {m[0], m[1], m[2], !m[1] && !m[0], m[1] ^ m[0]}, {fogFromShader,
                fogCoordAttr, fogFromSpecAlpha, fogCoordZ, fogBlendEquation});
        end
    endtask
    task automatic testParam();
        param(8'h82, 24'h123456);
        cyc(3);
        chk("paramScissor", 24'h123456, {scissorTop, scissorBottom});
        axiRead(8'h82, 24'h123456, 2'h0);
        param(8'h70, 24'h00008d);
        cyc(3);
        chk("paramFog", 3'h7, {fogFromShader, fogBlendEquation, fogModeExp2});
    endtask
    // Pattern 0010 with repeat two, counter reset in mid-line
    task automatic testStipple();
        axiWrite(8'h84, 24'h000002, 2'h0);
        axiWrite(8'h85, 24'h000002, 2'h0);
        step(1'b1);
        for (int k = 0; k < 4; k++)
        begin
            chk("stipple", k / 2 == 1, stippleOn);
            if (k < 3) step(1'b0);
        end
        axiWrite(8'h85, 24'h800002, 2'h0);
        cyc(3);
        chk("stippleReset", 1'b0, stippleOn);
        axiRead(8'h85, 24'h000002, 2'h0);
        step(1'b0);
        step(1'b0);
        chk("stippleAfter", 1'b1, stippleOn);
    endtask
    // Bottom-Y substitution, including the wrap below zero
    task automatic testLoc();
        axiWrite(8'h8a, 24'h81100d, 2'h0);
        shaderLocationUsed <= 1'b1;
        pixelY <= 12'h030;
        cyc(3);
        chk("locY", 13'h10d0, {locationYSubtract, locationY});
        chk("miscSet", 5'h1d, {texcoordPrecisionBoost, texcoordRoundMode,
            diffusePremodulated, specularPremodulated, fogPremodulated});
        pixelY <= 12'h130;
        cyc(3);
        chk("locYWrap", 13'h1fd0, {locationYSubtract, locationY});
        shaderLocationUsed <= 1'b0;
        cyc(3);
        chk("locYPlain", 13'h0130, {locationYSubtract, locationY});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        testReset();
        testTable();
        testUnmapped();
        testFogCtl();
        testParam();
        testStipple();
        testLoc();
        conclude();
    end
endmodule // tb_top
`default_nettype wire

//--- common/frs_map.vh
`ifndef FRS_MAP_VH
`define FRS_MAP_VH
// Parameter word sub-addresses
`define FRS_SUB_FOG_CTL 8'h70
`define FRS_SUB_FOG_GB 8'h71
`define FRS_SUB_FOG_R 8'h72
`define FRS_SUB_FOG_START 8'h73
`define FRS_SUB_RCP_MANT 8'h75
`define FRS_SUB_RCP_EXP 8'h76
`define FRS_SUB_FOG_END 8'h77
`define FRS_SUB_DENSITY 8'h78
`define FRS_SUB_CW_VERT 8'h80
`define FRS_SUB_CW_HORZ 8'h81
`define FRS_SUB_SC_VERT 8'h82
`define FRS_SUB_SC_HORZ 8'h83
`define FRS_SUB_STIP_PAT 8'h84
`define FRS_SUB_STIP_RPT 8'h85
`define FRS_SUB_SOLID_RGB 8'h86
`define FRS_SUB_SOLID_A 8'h87
`define FRS_SUB_GUARD_L 8'h88
`define FRS_SUB_GUARD_R 8'h89
`define FRS_SUB_MISC 8'h8a
// Writable bit masks per word
`define FRS_MSK_FOG_CTL 24'h0000ff
`define FRS_MSK_FOG_GB 24'h7ff7ff
`define FRS_MSK_FOG_R 24'h0007ff
`define FRS_MSK_FP15 24'h007fff
`define FRS_MSK_RCP_MANT 24'h00000f
`define FRS_MSK_RCP_EXP 24'h0000ff
`define FRS_MSK_DENSITY 24'h1fff00
`define FRS_MSK_FULL 24'hffffff
`define FRS_MSK_STIP_PAT 24'h00ffff
`define FRS_MSK_STIP_RPT 24'h00ffff
`define FRS_MSK_ALPHA 24'h0000ff
`define FRS_MSK_GUARD 24'h001fff
`define FRS_MSK_MISC 24'h81ffff
// Field positions
`define FRS_BIT_FOG_SHADER 7
`define FRS_BIT_FOG_ATTR 6
`define FRS_BIT_FOG_SPEC 5
`define FRS_BIT_FOG_DEPTH 4
`define FRS_BIT_FOG_EQ 3
`define FRS_BIT_STIP_RST 23
`define FRS_BIT_TX_BOOST 23
`define FRS_BIT_TX_ROUND 16
`define FRS_BIT_BOTY_EN 3
// Fog mode codes
`define FRS_MODE_LOCAL 3'h0
`define FRS_MODE_LINEAR 3'h2
`define FRS_MODE_EXP 3'h4
`define FRS_MODE_EXP2 3'h5
// Bus offsets: byte address is four times the sub-address
`define FRS_AXI_WORD_ADDR 0
// Reset values
`define FRS_RST_WORD 24'h000000
`endif

//--- src/frs_fog_raster_regs.v
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "frs_map.vh"
module frs_fog_raster_regs #(
    parameter ADDR_W = 10
) (
    input wire ref_clk,
    input wire rst_n,
    // AXI4-Lite slave
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Parameter word stream from the command processor
    input wire paramValid,
    input wire [31:0] paramWord,
    // Line stepping from the rasteriser
    input wire lineStart,
    input wire linePixelStep,
    input wire [11:0] pixelY,
    input wire shaderLocationUsed,
    // Decoded fog controls
    output reg fogFromShader,
    output reg fogCoordAttr,
    output reg fogCoordZ,
    output reg fogFromSpecAlpha,
    output reg fogBlendEquation,
    output reg fogModeLocal,
    output reg fogModeLinear,
    output reg fogModeExp,
    output reg fogModeExp2,
    output reg fogModeReserved,
    output reg [10:0] fogColourRed,
    output reg [10:0] fogColourGreen,
    output reg [10:0] fogColourBlue,
    output reg [14:0] fogStart,
    output reg [14:0] fogEnd,
    output reg [3:0] fogRecipMantissa,
    output reg [7:0] fogRecipExponent,
    output reg [12:0] fogDensity,
    // Clip rectangles
    output reg [11:0] colourClipTop,
    output reg [11:0] colourClipBottom,
    output reg [11:0] colourClipLeft,
    output reg [11:0] colourClipRight,
    output reg [11:0] scissorTop,
    output reg [11:0] scissorBottom,
    output reg [11:0] scissorLeft,
    output reg [11:0] scissorRight,
    output reg [12:0] guardLeftLimit,
    output reg [12:0] guardRightLimit,
    // Solid colour
    output reg [7:0] solidRed,
    output reg [7:0] solidGreen,
    output reg [7:0] solidBlue,
    output reg [7:0] solidAlpha,
    // Misc raster
    output reg texcoordPrecisionBoost,
    output reg texcoordRoundMode,
    output reg diffusePremodulated,
    output reg specularPremodulated,
    output reg fogPremodulated,
    output reg locationYSubtract,
    output reg [11:0] locationY,
    // Stipple output
    output reg stippleOn
);

////////////////////////////////////////////////////////////////////////////////
// Register file, one 24-bit payload per sub-address
reg [23:0] regsQ [0:31]; // Index 0..15 fog range, 16..31 misc range
reg [15:0] rptCntQ; // Stipple repeat counter
reg [3:0] patIdxQ; // Stipple pattern bit index
reg rstPendQ; // Stipple reset request waiting to act
reg awTakenQ; // Write address captured
reg wTakenQ; // Write data captured
reg [ADDR_W-1:0] awAddrQ; // Captured write address
reg [31:0] wDataQ; // Captured write data
reg [3:0] wStrbQ; // Captured byte strobes
reg bValidQ; // Write response pending
reg [1:0] bRespQ; // Write response code
reg rValidQ; // Read data pending
reg [31:0] rDataQ; // Read data
reg [1:0] rRespQ; // Read response code
integer i;

// Writable mask for a sub-address, zero for reserved ones
function [23:0] subMask;
    input [7:0] sub;
    begin
        case (sub)
            `FRS_SUB_FOG_CTL: subMask = `FRS_MSK_FOG_CTL;
            `FRS_SUB_FOG_GB: subMask = `FRS_MSK_FOG_GB;
            `FRS_SUB_FOG_R: subMask = `FRS_MSK_FOG_R;
            `FRS_SUB_FOG_START: subMask = `FRS_MSK_FP15;
            `FRS_SUB_RCP_MANT: subMask = `FRS_MSK_RCP_MANT;
            `FRS_SUB_RCP_EXP: subMask = `FRS_MSK_RCP_EXP;
            `FRS_SUB_FOG_END: subMask = `FRS_MSK_FP15;
            `FRS_SUB_DENSITY: subMask = `FRS_MSK_DENSITY;
            `FRS_SUB_CW_VERT: subMask = `FRS_MSK_FULL;
            `FRS_SUB_CW_HORZ: subMask = `FRS_MSK_FULL;
            `FRS_SUB_SC_VERT: subMask = `FRS_MSK_FULL;
            `FRS_SUB_SC_HORZ: subMask = `FRS_MSK_FULL;
            `FRS_SUB_STIP_PAT: subMask = `FRS_MSK_STIP_PAT;
            `FRS_SUB_STIP_RPT: subMask = `FRS_MSK_STIP_RPT;
            `FRS_SUB_SOLID_RGB: subMask = `FRS_MSK_FULL;
            `FRS_SUB_SOLID_A: subMask = `FRS_MSK_ALPHA;
            `FRS_SUB_GUARD_L: subMask = `FRS_MSK_GUARD;
            `FRS_SUB_GUARD_R: subMask = `FRS_MSK_GUARD;
            `FRS_SUB_MISC: subMask = `FRS_MSK_MISC;
            default: subMask = 24'h000000;
        endcase
    end
endfunction

// Slot index inside the register file, both ranges folded together
function [4:0] subSlot;
    input [7:0] sub;
    begin
        // Fog range lands in slots 0..15, misc range in 16..31
        subSlot = {sub[7], sub[3:0]};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Bus write side: address and data in any order, response after both
wire [7:0] busSub = awAddrQ[9:2]; // Byte address is four times the sub-address
wire busWrite = awTakenQ && wTakenQ && !bValidQ;
wire [23:0] strbMask = {{8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
wire [7:0] parSub = paramWord[31:24];
wire [23:0] parPay = paramWord[23:0];
wire stipRstWr; // Reset bit written as one this cycle

assign s_axi_awready = !awTakenQ;
assign s_axi_wready = !wTakenQ;
assign s_axi_bvalid = bValidQ;
assign s_axi_bresp = bRespQ;
assign s_axi_arready = !rValidQ;
assign s_axi_rvalid = rValidQ;
assign s_axi_rdata = rDataQ;
assign s_axi_rresp = rRespQ;
assign stipRstWr = (paramValid && parSub == `FRS_SUB_STIP_RPT && parPay[`FRS_BIT_STIP_RST])
    || (busWrite && busSub == `FRS_SUB_STIP_RPT && wStrbQ[2]
    && wDataQ[`FRS_BIT_STIP_RST]);

// Bus handshake state
always @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        awTakenQ <= 1'b0;
        wTakenQ <= 1'b0;
        awAddrQ <= {ADDR_W{1'b0}};
        wDataQ <= 32'h00000000;
        wStrbQ <= 4'h0;
        bValidQ <= 1'b0;
        bRespQ <= 2'h0;
        rValidQ <= 1'b0;
        rDataQ <= 32'h00000000;
        rRespQ <= 2'h0;
    end
    else
    begin
        if (s_axi_awvalid && !awTakenQ)
        begin
            awTakenQ <= 1'b1;
            awAddrQ <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !wTakenQ)
        begin
            wTakenQ <= 1'b1;
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
        end
        // Both halves present: commit and answer
        if (busWrite)
        begin
            bValidQ <= 1'b1;
            bRespQ <= (subMask(busSub) == 24'h000000) ? 2'h2 : 2'h0;
        end
        else if (bValidQ && s_axi_bready)
        begin
            bValidQ <= 1'b0;
            awTakenQ <= 1'b0;
            wTakenQ <= 1'b0;
        end
        // Read answers one cycle after the address
        if (s_axi_arvalid && !rValidQ)
        begin
            rValidQ <= 1'b1;
            rDataQ <= {8'h00, regsQ[subSlot(s_axi_araddr[9:2])]
                & subMask(s_axi_araddr[9:2])};
            rRespQ <= (subMask(s_axi_araddr[9:2]) == 24'h000000) ? 2'h2 : 2'h0;
        end
        else if (rValidQ && s_axi_rready)
        begin
            rValidQ <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register storage: parameter words first, bus write after (bus wins a clash)
always @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        for (i = 0; i < 32; i = i + 1)
            regsQ[i] <= `FRS_RST_WORD;
    end
    else
    begin
        if (paramValid && subMask(parSub) != 24'h000000)
        begin
            regsQ[subSlot(parSub)] <= parPay & subMask(parSub);
        end
        if (busWrite && subMask(busSub) != 24'h000000)
        begin
            regsQ[subSlot(busSub)] <= (regsQ[subSlot(busSub)] & ~strbMask)
                | (wDataQ[23:0] & strbMask & subMask(busSub));
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Stipple pattern walker with self-clearing reset
wire [23:0] stipRpt = regsQ[5'h15];
wire [23:0] stipPat = regsQ[5'h14];
wire [15:0] rptFactor = stipRpt[15:0];

always @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rptCntQ <= 16'h0000;
        patIdxQ <= 4'h0;
        rstPendQ <= 1'b0;
        stippleOn <= 1'b0;
    end
    else
    begin
        // Reset request seen this cycle is held until it acts
        if (stipRstWr)
            rstPendQ <= 1'b1;
        else if (rstPendQ)
            rstPendQ <= 1'b0;
        if (rstPendQ || lineStart)
        begin
            rptCntQ <= 16'h0000;
            patIdxQ <= 4'h0;
        end
        else if (linePixelStep)
        begin
            // Hold one pattern bit for the repeat factor, then advance
            if (rptCntQ + 16'h0001 >= rptFactor)
            begin
                rptCntQ <= 16'h0000;
                patIdxQ <= patIdxQ + 4'h1;
            end
            else
            begin
                rptCntQ <= rptCntQ + 16'h0001;
            end
        end
        stippleOn <= stipPat[patIdxQ];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Decoded outputs, registered
wire [23:0] fogCtl = regsQ[5'h00];
wire [23:0] misc = regsQ[5'h1a];

always @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        fogFromShader <= 1'b0;
        fogCoordAttr <= 1'b0;
        fogCoordZ <= 1'b0;
        fogFromSpecAlpha <= 1'b0;
        fogBlendEquation <= 1'b0;
        fogModeLocal <= 1'b1;
        fogModeLinear <= 1'b0;
        fogModeExp <= 1'b0;
        fogModeExp2 <= 1'b0;
        fogModeReserved <= 1'b0;
        fogColourRed <= 11'h000;
        fogColourGreen <= 11'h000;
        fogColourBlue <= 11'h000;
        fogStart <= 15'h0000;
        fogEnd <= 15'h0000;
        fogRecipMantissa <= 4'h0;
        fogRecipExponent <= 8'h00;
        fogDensity <= 13'h0000;
        colourClipTop <= 12'h000;
        colourClipBottom <= 12'h000;
        colourClipLeft <= 12'h000;
        colourClipRight <= 12'h000;
        scissorTop <= 12'h000;
        scissorBottom <= 12'h000;
        scissorLeft <= 12'h000;
        scissorRight <= 12'h000;
        guardLeftLimit <= 13'h0000;
        guardRightLimit <= 13'h0000;
        solidRed <= 8'h00;
        solidGreen <= 8'h00;
        solidBlue <= 8'h00;
        solidAlpha <= 8'h00;
        texcoordPrecisionBoost <= 1'b0;
        texcoordRoundMode <= 1'b0;
        diffusePremodulated <= 1'b0;
        specularPremodulated <= 1'b0;
        fogPremodulated <= 1'b0;
        locationYSubtract <= 1'b0;
        locationY <= 12'h000;
    end
    else
    begin
        // Shader takes over fog; bits 7 and 6 are copied straight to the outputs
        fogFromShader <= fogCtl[`FRS_BIT_FOG_SHADER];
        fogCoordAttr <= fogCtl[`FRS_BIT_FOG_ATTR];
        // Depth select only counts when the attribute is not chosen
        fogCoordZ <= !fogCtl[`FRS_BIT_FOG_ATTR] && fogCtl[`FRS_BIT_FOG_DEPTH];
        fogFromSpecAlpha <= fogCtl[`FRS_BIT_FOG_SPEC];
        fogBlendEquation <= fogCtl[`FRS_BIT_FOG_EQ];
        fogModeLocal <= fogCtl[2:0] == `FRS_MODE_LOCAL;
        fogModeLinear <= fogCtl[2:0] == `FRS_MODE_LINEAR;
        fogModeExp <= fogCtl[2:0] == `FRS_MODE_EXP;
        fogModeExp2 <= fogCtl[2:0] == `FRS_MODE_EXP2;
        fogModeReserved <= fogCtl[0] ? (fogCtl[2:1] != 2'h2) : fogCtl[2:1] == 2'h3;
        fogColourGreen <= regsQ[5'h01][22:12];
        fogColourBlue <= regsQ[5'h01][10:0];
        fogColourRed <= regsQ[5'h02][10:0];
        fogStart <= regsQ[5'h03][14:0];
        fogEnd <= regsQ[5'h07][14:0];
        fogRecipMantissa <= regsQ[5'h05][3:0];
        fogRecipExponent <= regsQ[5'h06][7:0];
        fogDensity <= regsQ[5'h08][20:8];
        colourClipTop <= regsQ[5'h10][23:12];
        colourClipBottom <= regsQ[5'h10][11:0];
        colourClipLeft <= regsQ[5'h11][23:12];
        colourClipRight <= regsQ[5'h11][11:0];
        scissorTop <= regsQ[5'h12][23:12];
        scissorBottom <= regsQ[5'h12][11:0];
        scissorLeft <= regsQ[5'h13][23:12];
        scissorRight <= regsQ[5'h13][11:0];
        solidRed <= regsQ[5'h16][23:16];
        solidGreen <= regsQ[5'h16][15:8];
        solidBlue <= regsQ[5'h16][7:0];
        solidAlpha <= regsQ[5'h17][7:0];
        guardLeftLimit <= regsQ[5'h18][12:0];
        guardRightLimit <= regsQ[5'h19][12:0];
        texcoordPrecisionBoost <= misc[`FRS_BIT_TX_BOOST];
        texcoordRoundMode <= misc[`FRS_BIT_TX_ROUND];
        diffusePremodulated <= misc[2];
        specularPremodulated <= misc[1];
        fogPremodulated <= misc[0];
        // Location Y: bottom minus pixel when enabled under shader location use
        locationYSubtract <= shaderLocationUsed && misc[`FRS_BIT_BOTY_EN];
        locationY <= (shaderLocationUsed && misc[`FRS_BIT_BOTY_EN])
            ? misc[15:4] - pixelY : pixelY;
    end
end

endmodule // frs_fog_raster_regs
`default_nettype wire
